// File: rtl/dnpsl_defines.svh
// Constants of the serial link-layer engine: codes, defaults, limits and timing
`ifndef DNPSL_DEFINES_SVH
`define DNPSL_DEFINES_SVH
`define DNPSL_ADDR_MAX 16'hFFEF
`define DNPSL_SELF_ADDR 16'hFFFC
`define DNPSL_OWN_DEF 16'h0001
`define DNPSL_MASTER_DEF 16'h0000
`define DNPSL_MASTERS 5
`define DNPSL_BAUD_38400 3'h0
`define DNPSL_BAUD_19200 3'h1
`define DNPSL_BAUD_9600 3'h2
`define DNPSL_BAUD_4800 3'h3
`define DNPSL_BAUD_2400 3'h4
`define DNPSL_BAUD_1200 3'h5
`define DNPSL_PAR_NONE 2'h0
`define DNPSL_PAR_EVEN 2'h1
`define DNPSL_PAR_ODD 2'h2
`define DNPSL_FC_ACK 4'h0
`define DNPSL_FC_NACK 4'h1
`define DNPSL_FC_CONF_DATA 4'h3
`define DNPSL_FC_UNCONF_DATA 4'h4
`define DNPSL_FC_NOT_SUPP 4'hF
`define DNPSL_TIMEOUT_DEF 16'h0014
`define DNPSL_RETRY_DEF 8'h00
`define DNPSL_DELAY_DEF 16'h0000
`define DNPSL_MS_NS 1000000
`define DNPSL_CLK_NS 10
`define DNPSL_LFSR_SEED 16'hACE1
`define DNPSL_LFSR_TAPS 16'hB400
`endif

// File: rtl/dnpsl_pkg.sv
// Types shared by the serial link-layer engine
`include "dnpsl_defines.svh"
package dnpsl_pkg;
  // Whole outstation link configuration, one set for all ports
  typedef struct packed {
    logic [15:0] ownAddr;
    logic [2:0] baud;
    logic [1:0] parity;
    logic twoStop;
    logic valEn;
    logic selfEn;
    logic [`DNPSL_MASTERS-1:0][15:0] master;
    logic halfDuplex;
    logic requestLinkConfirm;
    logic sendLinkConfirm;
    logic [15:0] confTimeout;
    logic [7:0] retries;
    logic [15:0] preDelay;
    logic [15:0] rtsOffDelay;
    logic [15:0] rtsOnDelay;
    logic [15:0] randMax;
  } dnpsl_cfg_type;
  // Link frame header
  typedef struct packed {
    logic prm;
    logic [3:0] fc;
    logic [15:0] dest;
    logic [15:0] src;
  } dnpsl_hdr_type;
  // Transmit sequencer, Gray along the half-duplex path from S_IDLE to S_WCONF
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_PRE = 3'h1,
    S_RTSUP = 3'h3,
    S_SEND = 3'h2,
    S_RTSDN = 3'h6,
    S_WCONF = 3'h7
  } dnpsl_state_type;
endpackage : dnpsl_pkg

// File: rtl/dnpsl_lfsr.sv
// Free-running pseudo-random source for collision-avoidance delay
`timescale 1ns/1ps
`include "dnpsl_defines.svh"
module dnpsl_lfsr (
  input wire logic clk,
  input wire logic sys_rst,
  output logic [15:0] value
);
  // Galois shift every cycle; request timing supplies the spread
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      value <= `DNPSL_LFSR_SEED;
    end else begin
      value <= {1'b0, value[15:1]} ^ (value[0] ? `DNPSL_LFSR_TAPS : 16'h0000);
    end
  end
endmodule : dnpsl_lfsr

// File: rtl/dnpsl_link.sv
// Serial link-layer engine of the outstation: filtering, framing, delays, RTS
//
// Behaviour
// [R1] Own address 0..65519, default 1
// [R2] Baud selectable 38400..1200, default 38400
// [R3] Parity none, even or odd; default none
// [R4] One or two stop bits, default one
// [R5] Validation on: only listed masters accepted
// [R6] Self address disabled: drop frames to FFFCh
// [R7] Self address enabled: accept; reply own address
// [R8] First master entry is unsolicited destination
// [R9] Five master entries 0..65519, default 0
// [R10] No handshake or half-duplex RTS/CTS
// [R11] Confirm request off: primaries use code 4
// [R12] Confirm request on: code 3, await, retry
// [R13] Secondary NACK/not-supported only if enabled
// [R14] Secondary only answers confirmed user data
// [R15] Confirm timeout 1..65535 ms, default 20
// [R16] Retries 0..255 after timeout, default 0
// [R17] Pre-transmit delay 0..65535 ms before sending
// [R18] RTS held the off delay after sending
// [R19] RTS raised the send delay before sending
// [R20] Random delay maximum 0..65535 ms
// [R21] One configuration set serves every port
// [R22] Wait pre-delay plus uniform random extra
`timescale 1ns/1ps
`include "dnpsl_defines.svh"
module dnpsl_link #(
  parameter int TICK_CYCLES = `DNPSL_MS_NS / `DNPSL_CLK_NS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire dnpsl_pkg::dnpsl_cfg_type cfgIn,
  input wire logic cfgLoad,
  input wire logic rxValid,
  input wire dnpsl_pkg::dnpsl_hdr_type rxHdr,
  input wire logic appFull,
  input wire logic rxUnsup,
  input wire logic txReq,
  input wire logic txUnsol,
  input wire logic [15:0] txDest,
  input wire logic txDone,
  output dnpsl_pkg::dnpsl_cfg_type cfg,
  output logic cfgReject,
  output logic rxAccept,
  output dnpsl_pkg::dnpsl_hdr_type rxHdrOut,
  output logic txTaken,
  output logic txStart,
  output dnpsl_pkg::dnpsl_hdr_type txHdr,
  output logic rts,
  output logic frameOk,
  output logic frameFail,
  output logic busy
);
  import dnpsl_pkg::*;
  // Reset-time configuration
  localparam dnpsl_cfg_type DEF_CFG = '{
    ownAddr: `DNPSL_OWN_DEF, baud: `DNPSL_BAUD_38400, parity: `DNPSL_PAR_NONE,
    twoStop: 1'b0, valEn: 1'b0, selfEn: 1'b0,
    master: {`DNPSL_MASTERS{`DNPSL_MASTER_DEF}},
    halfDuplex: 1'b0, requestLinkConfirm: 1'b0, sendLinkConfirm: 1'b0,
    confTimeout: `DNPSL_TIMEOUT_DEF, retries: `DNPSL_RETRY_DEF,
    preDelay: `DNPSL_DELAY_DEF, rtsOffDelay: `DNPSL_DELAY_DEF,
    rtsOnDelay: `DNPSL_DELAY_DEF, randMax: `DNPSL_DELAY_DEF};
  localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);
  dnpsl_state_type state; // Sequencer state
  dnpsl_state_type next_state; // Sequencer next state
  logic [16:0] tickCnt; // Clock cycles within one millisecond
  logic tick; // One-cycle millisecond pulse
  logic [16:0] msCnt; // Remaining milliseconds of current wait
  logic [7:0] retryLeft; // Retransmissions still allowed
  logic curConf; // Frame in flight expects a confirm
  logic secPend; // Secondary frame waiting to go
  logic [3:0] secFc; // Code of the pending secondary
  logic [15:0] secDest; // Master that earns the secondary
  logic [15:0] lfsrVal; // Pseudo-random word
  logic next_load; // Restart the millisecond wait
  logic [16:0] next_loadVal; // Value for the restarted wait
  logic next_rts;
  logic next_start;
  logic next_ok;
  logic next_fail;
  logic [7:0] next_retry;
  // Random source lives in its own small module
  dnpsl_lfsr u_lfsr (
    .clk(clk),
    .sys_rst(sys_rst),
    .value(lfsrVal)
  );
  // Per-entry master checks: range on load, source match on receive
  logic [`DNPSL_MASTERS-1:0] mstInRange;
  logic [`DNPSL_MASTERS-1:0] srcMatch;
  genvar gi;
  generate
    for (gi = 0; gi < `DNPSL_MASTERS; gi++) begin : g_master
      assign mstInRange[gi] = cfgIn.master[gi] <= `DNPSL_ADDR_MAX; // see [R9]
      assign srcMatch[gi] = rxHdr.src == cfg.master[gi]; // see [R5]
    end
  endgenerate
  // Configuration check; a bad set is refused whole
  wire ownInRange = cfgIn.ownAddr <= `DNPSL_ADDR_MAX; // see [R1]
  wire baudOk = cfgIn.baud <= `DNPSL_BAUD_1200; // see [R2]
  wire parityOk = cfgIn.parity <= `DNPSL_PAR_ODD; // see [R3]
  wire timeoutOk = cfgIn.confTimeout != 16'h0000; // see [R15]
  wire cfgOk = ownInRange & (&mstInRange) & baudOk & parityOk & timeoutOk;
  // Loads outside idle are refused so a frame never mixes two settings
  wire cfgTake = cfgLoad & cfgOk & (state == S_IDLE); // see [R21]
  wire [15:0] primaryMasterAddress = cfg.master[0];
  // Receive filtering
  wire dstSelf = rxHdr.dest == `DNPSL_SELF_ADDR;
  wire dstOwn = rxHdr.dest == cfg.ownAddr;
  wire addrOk = dstOwn | (dstSelf & cfg.selfEn); // see [R6] [R7]
  wire srcOk = ~cfg.valEn | (|srcMatch); // see [R5]
  wire acc = rxValid & addrOk & srcOk;
  wire isConfData = acc & rxHdr.prm & (rxHdr.fc == `DNPSL_FC_CONF_DATA); // see [R14]
  wire needSec = isConfData & cfg.sendLinkConfirm & (appFull | rxUnsup); // see [R13]
  wire [3:0] secFcSel = appFull ? `DNPSL_FC_NACK : `DNPSL_FC_NOT_SUPP;
  wire isAck = acc & ~rxHdr.prm & (rxHdr.fc == `DNPSL_FC_ACK)
    & (rxHdr.src == txHdr.dest) & (state == S_WCONF); // see [R12]
  // Start selection: pending secondary outranks a new primary
  wire idleFree = (state == S_IDLE) & ~cfgLoad;
  wire goSec = idleFree & secPend;
  wire goPri = idleFree & ~secPend & txReq;
  wire [15:0] priDest = txUnsol ? primaryMasterAddress : txDest; // see [R8]
  wire [3:0] priFc = cfg.requestLinkConfirm ? `DNPSL_FC_CONF_DATA
    : `DNPSL_FC_UNCONF_DATA; // see [R11] [R12]
  wire dnpsl_hdr_type startHdr = goSec
    ? dnpsl_hdr_type'{prm: 1'b0, fc: secFc, dest: secDest, src: cfg.ownAddr}
    : dnpsl_hdr_type'{prm: 1'b1, fc: priFc, dest: priDest, src: cfg.ownAddr}; // see [R7]
  // Uniform extra delay, scaled product keeps it within the maximum
  wire [32:0] randProd = lfsrVal * {1'b0, cfg.randMax} + lfsrVal; // see [R20]
  wire [16:0] preTotal = {1'b0, cfg.preDelay} + {1'b0, randProd[31:16]}; // see [R22] [R17]
  wire msDone = msCnt == 17'h00000;
  // Transmit sequencer decisions
  always_comb begin
    next_state = state;
    next_load = 1'b0;
    next_loadVal = 17'h00000;
    next_rts = rts;
    next_start = 1'b0;
    next_ok = 1'b0;
    next_fail = 1'b0;
    next_retry = retryLeft;
    unique case (state)
      S_IDLE: begin
        if (goSec | goPri) begin // Every frame waits its pre-delay
          next_state = S_PRE;
          next_load = 1'b1;
          next_loadVal = preTotal; // see [R17] [R22]
          next_retry = cfg.retries;
        end
      end
      S_PRE: begin
        if (msDone && cfg.halfDuplex) begin // Modem needs RTS lead time
          next_state = S_RTSUP;
          next_rts = 1'b1;
          next_load = 1'b1;
          next_loadVal = {1'b0, cfg.rtsOnDelay}; // see [R19]
        end else if (msDone) begin // Direct line, no handshake
          next_state = S_SEND;
          next_start = 1'b1; // see [R10]
        end
      end
      S_RTSUP: begin
        if (msDone) begin
          next_state = S_SEND;
          next_start = 1'b1; // see [R19]
        end
      end
      S_SEND: begin
        if (txDone && cfg.halfDuplex) begin // Hold RTS past last char
          next_state = S_RTSDN;
          next_load = 1'b1;
          next_loadVal = {1'b0, cfg.rtsOffDelay}; // see [R18]
        end else if (txDone && curConf) begin
          next_state = S_WCONF;
          next_load = 1'b1;
          next_loadVal = {1'b0, cfg.confTimeout}; // see [R15]
        end else if (txDone) begin
          next_state = S_IDLE;
          next_ok = 1'b1;
        end
      end
      S_RTSDN: begin
        if (msDone && curConf) begin
          next_state = S_WCONF;
          next_rts = 1'b0; // see [R18]
          next_load = 1'b1;
          next_loadVal = {1'b0, cfg.confTimeout}; // see [R15]
        end else if (msDone) begin
          next_state = S_IDLE;
          next_rts = 1'b0; // see [R18]
          next_ok = 1'b1;
        end
      end
      S_WCONF: begin
        if (isAck) begin // Confirm arrived in time
          next_state = S_IDLE;
          next_ok = 1'b1;
        end else if (msDone && retryLeft != 8'h00) begin // Resend same header
          next_state = S_PRE;
          next_retry = retryLeft - 8'h01; // see [R16]
          next_load = 1'b1;
          next_loadVal = preTotal; // see [R17]
        end else if (msDone) begin // Retries spent
          next_state = S_IDLE;
          next_fail = 1'b1; // see [R16]
        end
      end
    endcase
  end
  // Millisecond base restarts with each wait, so no wait comes up short
  always_ff @(posedge clk) begin
    if (sys_rst || next_load || tickCnt == TICK_LAST) begin
      tickCnt <= 17'h00000;
    end else begin
      tickCnt <= tickCnt + 17'h00001;
    end
    tick <= ~sys_rst & ~next_load & (tickCnt == TICK_LAST);
  end
  // Wait counter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      msCnt <= 17'h00000;
    end else if (next_load) begin
      msCnt <= next_loadVal;
    end else if (tick && !msDone) begin
      msCnt <= msCnt - 17'h00001;
    end
  end
  // Sequencer registers and status pulses
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= S_IDLE;
      rts <= 1'b0;
      txStart <= 1'b0;
      frameOk <= 1'b0;
      frameFail <= 1'b0;
      retryLeft <= 8'h00;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      rts <= next_rts;
      txStart <= next_start;
      frameOk <= next_ok;
      frameFail <= next_fail;
      retryLeft <= next_retry;
      busy <= next_state != S_IDLE;
    end
  end
  // Header of the frame in flight; kept for retries
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txHdr <= '0;
      curConf <= 1'b0;
      txTaken <= 1'b0;
    end else begin
      txTaken <= goPri;
      if (goSec || goPri) begin
        txHdr <= startHdr;
        curConf <= goPri & cfg.requestLinkConfirm; // see [R12]
      end
    end
  end
  // Secondary request: a new reason wins over the clear of the old one
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      secPend <= 1'b0;
      secFc <= `DNPSL_FC_NACK;
      secDest <= 16'h0000;
    end else if (needSec) begin
      secPend <= 1'b1; // see [R13] [R14]
      secFc <= secFcSel;
      secDest <= rxHdr.src;
    end else if (goSec || cfgTake) begin
      secPend <= 1'b0;
    end
  end
  // Accepted frames pass upward
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxAccept <= 1'b0;
      rxHdrOut <= '0;
    end else begin
      rxAccept <= acc; // see [R5] [R6]
      if (acc) begin
        rxHdrOut <= rxHdr;
      end
    end
  end
  // Active configuration; the single set every port reads
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg <= DEF_CFG; // see [R1] [R2] [R3] [R4] [R9]
      cfgReject <= 1'b0;
    end else begin
      cfgReject <= cfgLoad & ~cfgTake;
      if (cfgTake) begin
        cfg <= cfgIn; // see [R21]
      end
    end
  end
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_defaults;
    $past(sys_rst) |-> cfg.ownAddr == `DNPSL_OWN_DEF && cfg.baud == `DNPSL_BAUD_38400
      && cfg.parity == `DNPSL_PAR_NONE && !cfg.twoStop && cfg.master[0] == 16'h0000;
  endproperty
  a_defaults: assert property (p_defaults) else $error("bad reset config"); // see [R2]
  property p_own_range;
    cfg.ownAddr <= `DNPSL_ADDR_MAX && cfg.master[4] <= `DNPSL_ADDR_MAX;
  endproperty
  a_own_range: assert property (p_own_range) else $error("address out of range"); // see [R1]
  property p_valid;
    rxValid && cfg.valEn && !(|srcMatch) |=> !rxAccept;
  endproperty
  a_valid: assert property (p_valid) else $error("unlisted master accepted"); // see [R5]
  property p_self;
    rxValid && dstSelf && !cfg.selfEn |=> !rxAccept;
  endproperty
  a_self: assert property (p_self) else $error("self address not dropped"); // see [R6]
  property p_src;
    txStart |-> txHdr.src == cfg.ownAddr;
  endproperty
  a_src: assert property (p_src) else $error("wrong source address"); // see [R7]
  property p_prifc;
    txStart && txHdr.prm |-> txHdr.fc == (cfg.requestLinkConfirm ? `DNPSL_FC_CONF_DATA
      : `DNPSL_FC_UNCONF_DATA);
  endproperty
  a_prifc: assert property (p_prifc) else $error("wrong primary code"); // see [R11]
  property p_sec;
    txStart && !txHdr.prm |-> cfg.sendLinkConfirm;
  endproperty
  a_sec: assert property (p_sec) else $error("secondary while disabled"); // see [R13]
  property p_secunc;
    acc && rxHdr.fc == `DNPSL_FC_UNCONF_DATA && !secPend |=> !secPend;
  endproperty
  a_secunc: assert property (p_secunc) else $error("secondary for unconfirmed"); // see [R14]
  property p_timeout;
    state == S_WCONF && $past(state) != S_WCONF |-> msCnt == {1'b0, cfg.confTimeout};
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not loaded"); // see [R15]
  property p_retry;
    state == S_WCONF && msDone && !isAck && retryLeft != 8'h00
      |=> state == S_PRE && retryLeft == $past(retryLeft) - 8'h01;
  endproperty
  a_retry: assert property (p_retry) else $error("retry not taken"); // see [R16]
  property p_pre;
    state == S_PRE && $past(state) != S_PRE
      |-> msCnt >= {1'b0, cfg.preDelay} && msCnt <= {1'b0, cfg.preDelay} + {1'b0, cfg.randMax};
  endproperty
  a_pre: assert property (p_pre) else $error("pre delay out of bounds"); // see [R22]
  property p_rtshold;
    state == S_RTSUP || state == S_SEND && cfg.halfDuplex || state == S_RTSDN |-> rts;
  endproperty
  a_rtshold: assert property (p_rtshold) else $error("RTS dropped early"); // see [R18]
  property p_nohs;
    !cfg.halfDuplex && state != S_RTSDN |-> !rts;
  endproperty
  a_nohs: assert property (p_nohs) else $error("RTS without handshake"); // see [R10]
  c_conf: cover property (state == S_WCONF ##1 state == S_IDLE && frameOk);
  c_retry: cover property (state == S_WCONF ##1 state == S_PRE);
  c_sec: cover property (txStart && !txHdr.prm);
  c_hd: cover property (state == S_RTSDN ##1 state == S_IDLE);
endmodule : dnpsl_link

// File: verification/dnpsl_master_model.sv
// Master station and serialiser model on the far side of the link engine
`timescale 1ns/1ps
`include "dnpsl_defines.svh"
module dnpsl_master_model (
  input wire logic clk,
  input wire dnpsl_pkg::dnpsl_hdr_type txHdr,
  input wire logic txStart,
  input wire logic ackOn,
  output logic txDone,
  output logic rxValid,
  output dnpsl_pkg::dnpsl_hdr_type rxHdr
);
  import dnpsl_pkg::*;
  int lag = 3; // Line time of one frame in cycles, raised for a slow line
  dnpsl_hdr_type sent; // Header now on the line
  initial begin
    txDone = 0;
    rxValid = 0;
    rxHdr = '1;
  end
  // One header for one cycle; idle lines show the inverse, never a stale copy
  task automatic send(input dnpsl_hdr_type h);
    @(negedge clk);
    rxHdr = h;
    rxValid = 1;
    @(negedge clk);
    rxValid = 0;
    rxHdr = ~h;
  endtask : send
  // Serialise each started frame, then confirm it only when told to
  always begin
    @(posedge clk);
    if (txStart === 1'b1) begin
      sent = txHdr;
      repeat (lag) @(negedge clk);
      txDone = 1;
      @(negedge clk);
      txDone = 0;
      if (ackOn && sent.fc == `DNPSL_FC_CONF_DATA) begin
        send({1'b0, `DNPSL_FC_ACK, sent.src, sent.dest});
      end
    end
  end
endmodule : dnpsl_master_model

// File: verification/dnpsl_link_tb.sv
// Self-checking bench of the serial link-layer engine
`timescale 1ns/1ps
`include "dnpsl_defines.svh"
module dnpsl_link_tb;
  import dnpsl_pkg::*;
  localparam int TICK = 4; // Short ms keeps every delay cheap
  localparam int MS = TICK + 1; // Longest cost of one ms
  localparam int W_TAKEN = 0, W_START = 1, W_OK = 2, W_FAIL = 3, W_DONE = 4, W_RTS = 5;
  // Filter case: validation, self address, dest, src, accepted
  typedef struct packed {
    logic val;
    logic selfOn;
    logic [15:0] dest;
    logic [15:0] src;
    logic acc;
  } dnpsl_row_type;
  dnpsl_row_type rows [7] = '{
    '{1'b0, 1'b0, 16'h0021, 16'h1234, 1'b1},
    '{1'b0, 1'b0, 16'hFFFC, 16'h1234, 1'b0},
    '{1'b0, 1'b1, 16'hFFFC, 16'h1234, 1'b1},
    '{1'b1, 1'b0, 16'h0021, 16'h0105, 1'b1},
    '{1'b1, 1'b1, 16'hFFFC, 16'h0101, 1'b1},
    '{1'b1, 1'b0, 16'h0021, 16'h0106, 1'b0},
    '{1'b0, 1'b0, 16'h0022, 16'h0101, 1'b0}
  };
  logic clk, sys_rst, cfgLoad, appFull, rxUnsup, txReq, txUnsol, txDone, rxValid, ackOn;
  logic cfgReject, rxAccept, txTaken, txStart, rts, frameOk, frameFail, busy;
  logic [15:0] txDest;
  dnpsl_cfg_type cfgIn, cfg, b, c, p;
  dnpsl_hdr_type rxHdr, rxHdrOut, txHdr;
  int n_mismatch = 0, checks_done = 0, starts = 0, rtsRun = 0, n = 0;
  dnpsl_link #(.TICK_CYCLES(TICK)) uut (
    .clk(clk), .sys_rst(sys_rst), .cfgIn(cfgIn), .cfgLoad(cfgLoad), .rxValid(rxValid),
    .rxHdr(rxHdr), .appFull(appFull), .rxUnsup(rxUnsup), .txReq(txReq), .txUnsol(txUnsol),
    .txDest(txDest), .txDone(txDone), .cfg(cfg), .cfgReject(cfgReject), .rxAccept(rxAccept),
    .rxHdrOut(rxHdrOut), .txTaken(txTaken), .txStart(txStart), .txHdr(txHdr), .rts(rts),
    .frameOk(frameOk), .frameFail(frameFail), .busy(busy));
  dnpsl_master_model model (
    .clk(clk), .txHdr(txHdr), .txStart(txStart), .ackOn(ackOn), .txDone(txDone),
    .rxValid(rxValid), .rxHdr(rxHdr));
  // 100 MHz clock
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // Count started frames and the length of the current RTS run
  always @(posedge clk) begin
    if (txStart === 1'b1) starts <= starts + 1;
    rtsRun <= (rts === 1'b1) ? rtsRun + 1 : 0;
  end
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
  // Power-on set: 38400 baud, no parity, one stop, masters 0, delays 0
  function automatic dnpsl_cfg_type dflt();
    dnpsl_cfg_type d;
    d = '0;
    d.ownAddr = 16'h0001;
    d.confTimeout = 16'h0014;
    return d;
  endfunction : dflt
  function automatic logic sig(input int s);
    case (s)
      W_TAKEN: return txTaken;
      W_START: return txStart;
      W_OK: return frameOk;
      W_FAIL: return frameFail;
      W_DONE: return txDone;
      W_RTS: return rts;
      default: return busy;
    endcase
  endfunction : sig
  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic note(input string s);
    $display("test %s done at %0t", s, $time);
  endtask : note
  // Bounded wait for an output level; n holds the cycles spent
  task automatic waitSig(input int s, input logic v, input int lim, input bit must);
    n = 0;
    while (sig(s) !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (must) chk(sig(s), v);
  endtask : waitSig
  // Offer a set; cfg and cfgReject are settled on return
  task automatic load(input dnpsl_cfg_type s);
    @(negedge clk);
    cfgIn = s;
    cfgLoad = 1;
    @(negedge clk);
    cfgLoad = 0;
  endtask : load
  // Primary request held until taken; n ends as cycles from taken to start
  task automatic prim(input logic u, input logic [15:0] d);
    txReq = 1;
    txUnsol = u;
    txDest = d;
    waitSig(W_TAKEN, 1, 20, 1);
    txReq = 0;
    waitSig(W_START, 1, 500, 1);
  endtask : prim
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // Main sequence
  initial begin
    {cfgLoad, appFull, rxUnsup, txReq, txUnsol, ackOn} = '0;
    txDest = '0;
    cfgIn = '0;
    sys_rst = 1;
    repeat (8) @(negedge clk);
    sys_rst = 0;
    chk({busy, rts, cfg}, {2'b00, dflt()});
    note("reset");
    b = dflt();
    b.ownAddr = 16'h0021;
    b.master = {16'h0105, 16'h0104, 16'h0103, 16'h0102, 16'h0101};
    foreach (rows[i]) begin
      c = b;
      c.valEn = rows[i].val;
      c.selfEn = rows[i].selfOn;
      load(c);
      model.send({1'b1, `DNPSL_FC_UNCONF_DATA, rows[i].dest, rows[i].src});
      chk(rxAccept, rows[i].acc);
      if (rows[i].acc)
        chk(rxHdrOut, {1'b1, `DNPSL_FC_UNCONF_DATA, rows[i].dest, rows[i].src});
    end
    note("filter");
    p = c;
    // Every line code is taken, bad fields refuse the whole set
    for (int k = 0; k < 12; k++) begin
      c = b;
      c.baud = 3'(k % 6);
      c.parity = 2'(k % 3);
      c.twoStop = k[0];
      case (k)
        6: c.ownAddr = 16'hFFF0;
        7: c.master[3] = 16'hFFF0;
        8: c.baud = 3'h6;
        9: c.parity = 2'h3;
        10: c.confTimeout = 16'h0000;
        11: c.ownAddr = 16'hFFEF;
        default: ;
      endcase
      load(c);
      chk(cfgReject, k > 5 && k < 11);
      chk(cfg, (k > 5 && k < 11) ? p : c);
      if (k < 6 || k > 10) p = c;
    end
    note("config");
    load(b);
    prim(1'b0, 16'h0042);
    chk(n, 1);
    chk({rts, txHdr}, {2'b01, `DNPSL_FC_UNCONF_DATA, 32'h00420021});
    waitSig(W_OK, 1, 50, 1);
    prim(1'b1, 16'h0042);
    chk(txHdr.dest, 16'h0101);
    waitSig(W_OK, 1, 50, 1);
    note("unconfirmed");
    for (int k = 0; k < 3; k++) begin
      c = b;
      c.preDelay = 16'(3 - k);
      c.randMax = 16'(3 * k);
      load(c);
      prim(1'b0, 16'h0042);
      chk(n >= (3 - k) * TICK && n <= (4 + 2 * k) * MS + 3, 1);
      waitSig(W_OK, 1, 50, 1);
    end
    note("delays");
    for (int r = 0; r < 3; r += 2) begin
      c = b;
      c.requestLinkConfirm = 1;
      c.retries = 8'(r);
      c.confTimeout = 16'h0001;
      load(c);
      starts = 0;
      prim(1'b0, 16'h0042);
      chk(txHdr.fc, `DNPSL_FC_CONF_DATA);
      waitSig(W_FAIL, 1, 300, 1);
      chk(starts, r + 1);
    end
    c.retries = 8'h00;
    c.confTimeout = 16'h0014;
    ackOn = 1;
    load(c);
    prim(1'b0, 16'h0042);
    waitSig(W_OK, 1, 150, 1);
    ackOn = 0;
    note("confirmed");
    c = b;
    c.halfDuplex = 1;
    c.rtsOnDelay = 16'h0002;
    c.rtsOffDelay = 16'h0003;
    model.lag = 7;
    load(c);
    prim(1'b0, 16'h0042);
    chk(rts === 1'b1 && rtsRun >= 2 * TICK, 1);
    waitSig(W_DONE, 1, 20, 1);
    waitSig(W_RTS, 0, 50, 1);
    chk(n >= 3 * TICK && n <= 4 * MS + 3, 1);
    waitSig(W_OK, 1, 5, 1);
    model.lag = 3;
    note("half duplex");
    // Secondary frames: NACK, not supported, none for unconfirmed, none when off
    for (int k = 0; k < 4; k++) begin
      c = b;
      c.sendLinkConfirm = (k != 3);
      load(c);
      appFull = (k != 1);
      rxUnsup = (k != 0);
      model.send({1'b1, (k == 2) ? `DNPSL_FC_UNCONF_DATA : `DNPSL_FC_CONF_DATA, 32'h00210077});
      appFull = 0;
      rxUnsup = 0;
      waitSig(W_START, 1, 40, 0);
      chk(n < 40, k < 2);
      if (k < 2) chk({txHdr.fc, txHdr.dest}, {(k == 1) ? 4'hF : 4'h1, 16'h0077});
      waitSig(-1, 0, 100, 1);
    end
    note("secondary");
    c = b;
    c.preDelay = 16'h0005;
    load(c);
    txReq = 1;
    waitSig(W_TAKEN, 1, 20, 1);
    txReq = 0;
    sys_rst = 1;
    @(negedge clk);
    sys_rst = 0;
    chk({busy, rts, txStart, cfg}, {3'b000, dflt()});
    note("second reset");
    conclude();
  end
endmodule : dnpsl_link_tb
